// File: logic/nmss_nmi_source_status.sv
`timescale 1ns/1ps
// Overview of operation
// - a pci parity or system error, or either processor internal error, requests the nmi.
// - status bit 7 reads 1 while a parity-error nmi is pending, and ignores writes.
// - status bit 6 reads 1 when the low channel-check input has requested an nmi; read only.
// - status bit 5 shows the present output of the speaker tone counter 2.
// - status bit 4 toggles on every memory refresh event.
// - bit 3 set disables channel-check nmi and clears its status; clear enables it.
// - bit 2 set disables parity nmi and clears its status; clear enables it.
// - bit 0 is the read/write counter 2 gate and bit 1 the read/write speaker data.
// - bit 7 of the index port byte masks the nmi output when set.
// - with power management enabled, an inactivity timeout asserts the smi.
// - smi outranks the maskable interrupt but leaves nmi asserted, and nmi outranks all maskable interrupts.
module nmss_nmi_source_status
(
	input	wire logic		clk_sys,
	input	wire logic		rst_b,
	input	wire logic [15:0]	io_addr,
	input	wire logic		io_wr,
	input	wire logic		io_rd,
	input	wire logic [7:0]	io_wdata,
	output	logic [7:0]		io_rdata_ff,
	input	wire logic		pci_perr_b,
	input	wire logic		pci_serr_b,
	input	wire logic		processor_internal_error_a,
	input	wire logic		processor_internal_error_b,
	input	wire logic		chan_check_b,
	input	wire logic		counter2_out,
	input	wire logic		refresh_event,
	input	wire logic		pm_enable,
	input	wire logic		inactivity_timeout,
	input	wire logic		maskable_req,
	output	logic			nmi_ff,
	output	logic			smi_ff,
	output	logic			intr_ff,
	output	logic			counter2_gate_ff,
	output	logic			speaker_data_ff,
	output	logic [7:0]		rtc_index_ff
);
	nmss_src_if	src ();

	logic [3:0]	ctrl_ff;
	logic [3:0]	nxt_ctrl;
	logic [7:0]	nxt_index;
	logic		refresh_ff;
	logic		nxt_refresh;
	logic		wr_status;
	logic		wr_index;

	////////////////////////////////////////////////////////////////////////////
	// source events toward the status latch
	always_comb
	begin
		src.parity_event   = !pci_perr_b | !pci_serr_b;
		src.chanchk_active = !chan_check_b;
		src.parity_dis     = ctrl_ff[nmss_pkg::BIT_PARITY_DIS];
		src.chanchk_dis    = ctrl_ff[nmss_pkg::BIT_CHANCHK_DIS];
	end

	nmss_source_latch u_latch
	(
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.src     (src)
	);

	////////////////////////////////////////////////////////////////////////////
	// register writes and refresh toggle
	always_comb
	begin
		wr_status   = io_wr && (io_addr == nmss_pkg::ADDR_SOURCE_STATUS_CONTROL);
		wr_index    = io_wr && (io_addr == nmss_pkg::ADDR_GLOBAL_MASK_INDEX);
		nxt_ctrl    = wr_status ? io_wdata[3:0] : ctrl_ff;    // bits 7..4 ignore writes
		nxt_index   = wr_index ? io_wdata : rtc_index_ff;
		nxt_refresh = refresh_ff ^ refresh_event;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			ctrl_ff      <= nmss_pkg::RST_CTRL;
			rtc_index_ff <= nmss_pkg::RST_INDEX;
			refresh_ff   <= 1'b0;
		end
		else
		begin
			ctrl_ff      <= nxt_ctrl;
			rtc_index_ff <= nxt_index;
			refresh_ff   <= nxt_refresh;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt outputs, read data and gate pins
	logic		nxt_nmi;
	logic		nxt_smi;
	logic		nxt_intr;
	logic [7:0]	nxt_rdata;

	always_comb
	begin
		nxt_nmi = !rtc_index_ff[nmss_pkg::BIT_GLOBAL_MASK]
			&& (src.parity_pend || src.chanchk_pend
			|| processor_internal_error_a || processor_internal_error_b);
		nxt_smi  = pm_enable && inactivity_timeout;
		// lower-priority requests held off behind smi and nmi
		nxt_intr = maskable_req && !nxt_smi && !nxt_nmi;
		nxt_rdata = 8'h00;
		if (io_rd && io_addr == nmss_pkg::ADDR_SOURCE_STATUS_CONTROL)
		begin
			nxt_rdata[nmss_pkg::BIT_PARITY_STATUS]  = src.parity_pend;
			nxt_rdata[nmss_pkg::BIT_CHANCHK_STATUS] = src.chanchk_pend;
			nxt_rdata[nmss_pkg::BIT_SPK_OUT]        = counter2_out;
			nxt_rdata[nmss_pkg::BIT_REFRESH]        = refresh_ff;
			nxt_rdata[3:0]                          = ctrl_ff;
		end
		else if (io_rd && io_addr == nmss_pkg::ADDR_GLOBAL_MASK_INDEX)
			nxt_rdata = rtc_index_ff;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			nmi_ff           <= 1'b0;
			smi_ff           <= 1'b0;
			intr_ff          <= 1'b0;
			io_rdata_ff      <= 8'h00;
			counter2_gate_ff <= 1'b0;
			speaker_data_ff  <= 1'b0;
		end
		else
		begin
			nmi_ff           <= nxt_nmi;
			smi_ff           <= nxt_smi;
			intr_ff          <= nxt_intr;
			io_rdata_ff      <= nxt_rdata;
			counter2_gate_ff <= nxt_ctrl[nmss_pkg::BIT_CNT2_GATE];
			speaker_data_ff  <= nxt_ctrl[nmss_pkg::BIT_SPK_DATA];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_mask_blocks;
		@(posedge clk_sys) disable iff (!rst_b)
			rtc_index_ff[nmss_pkg::BIT_GLOBAL_MASK] |=> !nmi_ff;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks)
		else $error("nmi raised while globally masked");

	property p_parity_nmi;
		@(posedge clk_sys) disable iff (!rst_b)
			(!pci_perr_b && !ctrl_ff[nmss_pkg::BIT_PARITY_DIS]
			&& !nxt_ctrl[nmss_pkg::BIT_PARITY_DIS]
			&& !rtc_index_ff[nmss_pkg::BIT_GLOBAL_MASK] && !wr_index) |-> ##2 nmi_ff;
	endproperty
	a_parity_nmi: assert property (p_parity_nmi)
		else $error("parity error did not raise nmi");

	property p_nmi_holds;
		@(posedge clk_sys) disable iff (!rst_b)
			(src.chanchk_pend && !rtc_index_ff[nmss_pkg::BIT_GLOBAL_MASK]) |=> nmi_ff;
	endproperty
	a_nmi_holds: assert property (p_nmi_holds)
		else $error("nmi dropped while channel check pending");

	property p_smi;
		@(posedge clk_sys) disable iff (!rst_b)
			(pm_enable && inactivity_timeout) |=> smi_ff && !intr_ff;
	endproperty
	a_smi: assert property (p_smi)
		else $error("smi missing on inactivity timeout");

	property p_nmi_over_intr;
		@(posedge clk_sys) disable iff (!rst_b) nmi_ff |-> !intr_ff;
	endproperty
	a_nmi_over_intr: assert property (p_nmi_over_intr)
		else $error("maskable request passed during nmi");

	property p_refresh_toggle;
		@(posedge clk_sys) disable iff (!rst_b)
			refresh_event |=> refresh_ff != $past(refresh_ff);
	endproperty
	a_refresh_toggle: assert property (p_refresh_toggle)
		else $error("refresh bit failed to toggle");

	property p_gate_write;
		@(posedge clk_sys) disable iff (!rst_b)
			wr_status |=> counter2_gate_ff == $past(io_wdata[nmss_pkg::BIT_CNT2_GATE])
			&& speaker_data_ff == $past(io_wdata[nmss_pkg::BIT_SPK_DATA]);
	endproperty
	a_gate_write: assert property (p_gate_write)
		else $error("gate or speaker bit not updated");

	property p_status_read;
		@(posedge clk_sys) disable iff (!rst_b)
			(io_rd && io_addr == nmss_pkg::ADDR_SOURCE_STATUS_CONTROL)
			|=> io_rdata_ff[nmss_pkg::BIT_PARITY_STATUS] == $past(src.parity_pend)
			&& io_rdata_ff[nmss_pkg::BIT_CHANCHK_STATUS] == $past(src.chanchk_pend)
			&& io_rdata_ff[nmss_pkg::BIT_SPK_OUT] == $past(counter2_out);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read data wrong");

	// internal processor errors reach the nmi one cycle later when unmasked
	property p_ierr_nmi;
		@(posedge clk_sys) disable iff (!rst_b)
			((processor_internal_error_a || processor_internal_error_b)
			&& !rtc_index_ff[nmss_pkg::BIT_GLOBAL_MASK]) |=> nmi_ff;
	endproperty
	a_ierr_nmi: assert property (p_ierr_nmi)
		else $error("internal error did not raise nmi");

	// refresh bit and the channel-check and parity disable bits come back on a status read
	property p_ctrl_read;
		@(posedge clk_sys) disable iff (!rst_b)
			(io_rd && io_addr == nmss_pkg::ADDR_SOURCE_STATUS_CONTROL)
			|=> io_rdata_ff[nmss_pkg::BIT_REFRESH] == $past(refresh_ff)
			&& io_rdata_ff[nmss_pkg::BIT_CHANCHK_DIS] == $past(ctrl_ff[nmss_pkg::BIT_CHANCHK_DIS])
			&& io_rdata_ff[nmss_pkg::BIT_PARITY_DIS] == $past(ctrl_ff[nmss_pkg::BIT_PARITY_DIS]);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("refresh or enable bits read wrong");

	// the index byte, mask bit included, reads back as last written
	property p_index_read;
		@(posedge clk_sys) disable iff (!rst_b)
			(io_rd && io_addr == nmss_pkg::ADDR_GLOBAL_MASK_INDEX)
			|=> io_rdata_ff == $past(rtc_index_ff);
	endproperty
	a_index_read: assert property (p_index_read)
		else $error("index read data wrong");
endmodule // nmss_nmi_source_status

// File: common/nmss_pkg.sv
package nmss_pkg;
	// i/o port addresses
	localparam logic [15:0] ADDR_SOURCE_STATUS_CONTROL = 16'h0061;
	localparam logic [15:0] ADDR_GLOBAL_MASK_INDEX     = 16'h0070;
	// status/control byte fields
	localparam int BIT_PARITY_STATUS  = 7;
	localparam int BIT_CHANCHK_STATUS = 6;
	localparam int BIT_SPK_OUT        = 5;
	localparam int BIT_REFRESH        = 4;
	localparam int BIT_CHANCHK_DIS    = 3;
	localparam int BIT_PARITY_DIS     = 2;
	localparam int BIT_SPK_DATA       = 1;
	localparam int BIT_CNT2_GATE      = 0;
	// global mask bit within index byte
	localparam int BIT_GLOBAL_MASK    = 7;
	// reset values
	localparam logic [3:0] RST_CTRL   = 4'hC;
	localparam logic [7:0] RST_INDEX  = 8'h80;
endpackage

// File: common/nmss_src_if.sv
`timescale 1ns/1ps
interface nmss_src_if;
	logic	parity_event;
	logic	chanchk_active;
	logic	parity_dis;
	logic	chanchk_dis;
	logic	parity_pend;
	logic	chanchk_pend;
	modport ctrl (output parity_event, output chanchk_active, output parity_dis,
		output chanchk_dis, input parity_pend, input chanchk_pend);
	modport latch (input parity_event, input chanchk_active, input parity_dis,
		input chanchk_dis, output parity_pend, output chanchk_pend);
endinterface

// File: logic/nmss_source_latch.sv
`timescale 1ns/1ps
module nmss_source_latch
(
	input	wire logic	clk_sys,
	input	wire logic	rst_b,
	nmss_src_if.latch	src
);
	logic	parity_ff;
	logic	nxt_parity;
	logic	chanchk_ff;
	logic	nxt_chanchk;

	// sticky pending status, cleared while disabled
	always_comb
	begin
		nxt_parity  = src.parity_dis ? 1'b0 : (parity_ff | src.parity_event);
		nxt_chanchk = src.chanchk_dis ? 1'b0 : (chanchk_ff | src.chanchk_active);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			parity_ff  <= 1'b0;
			chanchk_ff <= 1'b0;
		end
		else
		begin
			parity_ff  <= nxt_parity;
			chanchk_ff <= nxt_chanchk;
		end
	end

	assign src.parity_pend  = parity_ff;
	assign src.chanchk_pend = chanchk_ff;

	property p_parity_cleared;
		@(posedge clk_sys) disable iff (!rst_b) src.parity_dis |=> !parity_ff;
	endproperty
	a_parity_cleared: assert property (p_parity_cleared)
		else $error("parity status not cleared while disabled");

	property p_chanchk_cleared;
		@(posedge clk_sys) disable iff (!rst_b) src.chanchk_dis |=> !chanchk_ff;
	endproperty
	a_chanchk_cleared: assert property (p_chanchk_cleared)
		else $error("channel check status not cleared while disabled");
endmodule // nmss_source_latch

// File: test/nmss_cpu_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module nmss_cpu_model
(
	input	wire logic		clk_sys,
	input	wire logic		rst_b,
	input	wire logic		nmi,
	input	wire logic		smi,
	input	wire logic		intr,
	output	logic [1:0]		svc_ff
);
	logic [1:0]	nxt_svc;
	// line the core takes first: 2 smi, 1 nmi, 3 intr
	always_comb
	begin
		nxt_svc = smi ? 2'h2 : nmi ? 2'h1 : intr ? 2'h3 : 2'h0;
		if (!rst_b)
			nxt_svc = 2'h0;
	end
	// register the pick
	always_ff @(posedge clk_sys)
	begin
		svc_ff <= nxt_svc;
	end
endmodule // nmss_cpu_model

// File: test/nmi_source_status_logic_tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module nmi_source_status_logic_tb_top;
	logic		clk_sys, rst_b, io_wr, io_rd, perr_b, serr_b, ierr_a, ierr_b;
	logic		cc_b, cnt2, refr, pm_en, tmo, mreq, rd_q, ref_x;
	logic		nmi, smi, intr, gate, spk;
	logic [1:0]	svc;
	logic [3:0]	ctl;
	logic [15:0]	io_addr;
	logic [7:0]	io_wdata, io_rdata_ff, rtc_idx;
	logic [31:0]	lf;
	logic [7:0]	exp_q[$];
	int		err_count, checked;

	nmss_nmi_source_status dut (.clk_sys(clk_sys), .rst_b(rst_b), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
		.pci_perr_b(perr_b), .pci_serr_b(serr_b), .processor_internal_error_a(ierr_a),
		.processor_internal_error_b(ierr_b), .chan_check_b(cc_b), .counter2_out(cnt2),
		.refresh_event(refr), .pm_enable(pm_en), .inactivity_timeout(tmo),
		.maskable_req(mreq), .nmi_ff(nmi), .smi_ff(smi), .intr_ff(intr),
		.counter2_gate_ff(gate), .speaker_data_ff(spk), .rtc_index_ff(rtc_idx));
	nmss_cpu_model cpu (.clk_sys(clk_sys), .rst_b(rst_b), .nmi(nmi), .smi(smi),
		.intr(intr), .svc_ff(svc));

	////////////////////////////////////////////////////////////////
	// clock, 40 ns period
	initial
	begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	// hang guard
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		tally_and_finish;
	end
	// read watcher: compares the oldest note
	always @(posedge clk_sys) rd_q <= io_rd;
	always @(negedge clk_sys)
		if (rd_q) check(io_rdata_ff, exp_q.pop_front(), "read data");

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(negedge clk_sys);
		io_addr = a;
		io_wdata = d;
		io_wr = w;
		io_rd = !w;
		@(negedge clk_sys);
		io_wr = 0;
		io_rd = 0;
	endtask
	task automatic w61(input logic [7:0] d);
		ctl = d[3:0];
		acc(nmss_pkg::ADDR_SOURCE_STATUS_CONTROL, d, 1'b1);
	endtask
	task automatic r61(input logic p, input logic c);
		exp_q.push_back({p, c, cnt2, ref_x, ctl});
		acc(nmss_pkg::ADDR_SOURCE_STATUS_CONTROL, 8'h00, 1'b0);
	endtask
	task automatic lines(input logic [2:0] e);
		check({5'h00, nmi, smi, intr}, {5'h00, e}, "nmi smi intr");
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{rst_b, io_wr, io_rd, ierr_a, ierr_b, cnt2, refr, pm_en, tmo, mreq, ref_x} = '0;
		{perr_b, serr_b, cc_b} = 3'h7;
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		lf = 32'h8e5df6c6;
		ctl = 4'hC;
		err_count = 0;
		checked = 0;
		cyc(10);
		rst_b = 1;
		check(rtc_idx, 8'h80, "index reset");
		lines(3'h0);
		r61(0, 0);
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			lf = lfsr(lf);
			cnt2 = lf[5];
			w61({6'h3F, lf[1:0]});
			check({6'h00, spk, gate}, {6'h00, lf[1:0]}, "gate speaker");
			r61(0, 0);
			refr = 1;
			cyc(1);
			refr = 0;
			ref_x = ~ref_x;
			r61(0, 0);
		end
		$display("control test done");
		acc(nmss_pkg::ADDR_GLOBAL_MASK_INDEX, 8'h0D, 1'b1);
		w61(8'h00);
		for (int s = 0; s < 3; s++)
		begin
			if (s == 2)
				w61(8'h04);
			{serr_b, perr_b} = (s == 1) ? 2'h1 : 2'h2;
			cyc(1);
			{serr_b, perr_b} = 2'h3;
			cyc(2);
			lines({s != 2, 2'h0});
			r61(s != 2, 0);
			w61(8'h04);
			w61(8'h00);
			cyc(2);
			lines(3'h0);
			r61(0, 0);
		end
		cc_b = 0;
		cyc(3);
		lines(3'h4);
		r61(0, 1);
		w61(8'h08);
		r61(0, 0);
		cc_b = 1;
		w61(8'h00);
		lines(3'h0);
		$display("source test done");
		acc(nmss_pkg::ADDR_GLOBAL_MASK_INDEX, 8'h8D, 1'b1);
		perr_b = 0;
		ierr_a = 1;
		cyc(1);
		perr_b = 1;
		cyc(2);
		lines(3'h0);
		r61(1, 0);
		ierr_a = 0;
		acc(nmss_pkg::ADDR_GLOBAL_MASK_INDEX, 8'h0D, 1'b1);
		cyc(2);
		lines(3'h4);
		w61(8'h04);
		w61(8'h00);
		$display("mask test done");
		mreq = 1;
		cyc(2);
		lines(3'h1);
		check({6'h00, svc}, 8'h03, "service pick");
		ierr_b = 1;
		tmo = 1;
		cyc(2);
		lines(3'h4);
		check({6'h00, svc}, 8'h01, "service pick");
		pm_en = 1;
		cyc(2);
		lines(3'h6);
		check({6'h00, svc}, 8'h02, "service pick");
		{ierr_b, tmo, pm_en, mreq} = 4'h0;
		cyc(2);
		lines(3'h0);
		acc(16'h0062, 8'hFF, 1'b1);
		exp_q.push_back(8'h00);
		acc(16'h0071, 8'h00, 1'b0);
		r61(0, 0);
		exp_q.push_back(8'h0D);
		acc(nmss_pkg::ADDR_GLOBAL_MASK_INDEX, 8'h00, 1'b0);
		cyc(2);
		$display("priority test done");
		tally_and_finish;
	end
endmodule // nmi_source_status_logic_tb_top
